/* core/scl_pkg.sv */
// constants, types and register map of the fixed-point scaler
package scl_pkg;
	// datapath widths, fixed per instance
	localparam int IN_W = 32;
	localparam int IN_FRAC = 24;
	localparam int OUT_W = 16;
	localparam int OUT_FRAC = 12;
	localparam int NLANE = 4;
	localparam int CHAN_W = 8;
	localparam int NSHIFT = 4;
	localparam int SEL_W = 2;
	localparam int SH_W = 6;
	localparam int SH_MAX = 8;
	localparam int LATENCY = 2;
	// wide working word: room for SH_MAX of gain and SH_MAX of attenuation
	localparam int EXT_W = IN_W + 2 * SH_MAX;
	localparam int DROP = IN_FRAC + SH_MAX - OUT_FRAC;
	localparam int KEEP_W = EXT_W - DROP;
	localparam int SUM_W = KEEP_W + 1;
	localparam logic signed [SH_W-1:0] SH_HI = SH_W'(SH_MAX);
	localparam logic signed [SH_W-1:0] SH_LO = -SH_HI;
	localparam logic signed [SUM_W-1:0] OUT_MAXV =
		SUM_W'((64'h0000_0000_0000_0001 << (OUT_W - 1)) - 1);
	localparam logic signed [SUM_W-1:0] OUT_MINV = ~OUT_MAXV;
	localparam logic signed [SUM_W-1:0] OUT_SYMV = -OUT_MAXV;

	// register bus
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] REG_SHCONST = 6'h04;
	localparam logic [ADDR_W-1:0] REG_SHVEC = 6'h08;
	localparam logic [ADDR_W-1:0] REG_STEP = 6'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h18;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN = 6'h1C;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 6'h20;
	localparam logic [ADDR_W-1:0] REG_SAT_CNT = 6'h24;
	localparam logic [ADDR_W-1:0] REG_SMP_CNT = 6'h28;
	// control fields
	localparam int CTRL_W = 5;
	localparam int CTRL_RND_LSB = 0;
	localparam int CTRL_SAT_LSB = 2;
	localparam int CTRL_VEC_BIT = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic signed [SH_W-1:0] SHIFT_RST = 6'h00;
	// interrupt bits
	localparam int IRQ_W = 2;
	localparam int IRQ_SAT = 0;
	localparam int IRQ_SMP = 1;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
	localparam logic [DATA_W-1:0] CNT_RST = 32'h0000_0000;

	typedef enum logic [1:0] {RND_TRUNC, RND_BIASED, RND_UNBIASED} scl_round_t;
	typedef enum logic [1:0] {SAT_NONE, SAT_ASYM, SAT_SYM} scl_sat_t;
	typedef struct packed {
		scl_round_t rnd;
		scl_sat_t sat;
	} scl_mode_t;
	typedef struct packed {
		logic v;
		logic [CHAN_W-1:0] chan;
	} scl_tag_t;
endpackage : scl_pkg

/* core/scl_lane.sv */
// one lane of the scaler: shift stage, then round and saturate stage
`timescale 1ns/1ps
module scl_lane
	import scl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// sample in
	input wire logic [IN_W-1:0] in_data,
	input wire logic signed [SH_W-1:0] in_shift,
	input wire scl_mode_t in_mode,
	// result out
	output logic [OUT_W-1:0] out_data,
	output logic out_flag
);
	logic signed [SH_W-1:0] amt;
	logic [SH_W-1:0] pos;
	logic signed [EXT_W-1:0] ext_in;
	logic signed [EXT_W-1:0] ext_q;
	scl_mode_t mode_q;
	logic signed [KEEP_W-1:0] kept;
	logic half;
	logic rest;
	logic lsb;
	logic inc;
	logic signed [SUM_W-1:0] sum;
	logic [OUT_W-1:0] low_kept;
	logic [OUT_W-1:0] next_out;
	logic next_flag;

	// out-of-range shifts clamp so a bad write cannot break the word
	always_comb begin
		amt = in_shift;
		if (in_shift > SH_HI) begin
			amt = SH_HI;
		end else if (in_shift < SH_LO) begin
			amt = SH_LO;
		end
		pos = SH_W'(amt + SH_HI);
	end
	// sign extension pads ones for negative data [RULE6]
	assign ext_in = EXT_W'($signed(in_data));

	// shift is applied first; positive drops MSBs at saturation [RULE3] [RULE5]
	always_ff @(posedge clock) begin
		if (srst) begin
			ext_q <= '0;
			mode_q <= '0;
		end else begin
			ext_q <= ext_in <<< pos;
			mode_q <= in_mode;
		end
	end

	// zero shift keeps the binary point: fixed DROP bits leave [RULE2] [RULE1]
	assign kept = ext_q[EXT_W-1:DROP];
	assign half = ext_q[DROP-1];
	assign rest = |ext_q[DROP-2:0];
	assign lsb = ext_q[DROP];
	assign low_kept = ext_q[DROP +: OUT_W];

	always_comb begin
		case (mode_q.rnd)
			RND_BIASED: inc = half; // [RULE8]
			RND_UNBIASED: inc = half & (rest | lsb); // [RULE9]
			default: inc = 1'b0; // [RULE7]
		endcase
		sum = {kept[KEEP_W-1], kept} + SUM_W'({1'b0, inc});
	end

	// saturation after rounding [RULE3] [RULE12] [RULE13]
	always_comb begin
		next_out = sum[OUT_W-1:0];
		next_flag = (sum > OUT_MAXV) || (sum < OUT_MINV);
		case (mode_q.sat)
			SAT_ASYM: begin
				if (sum > OUT_MAXV) begin
					next_out = OUT_MAXV[OUT_W-1:0];
				end else if (sum < OUT_MINV) begin
					next_out = OUT_MINV[OUT_W-1:0];
				end
			end
			SAT_SYM: begin
				next_flag = (sum > OUT_MAXV) || (sum < OUT_SYMV);
				if (sum > OUT_MAXV) begin
					next_out = OUT_MAXV[OUT_W-1:0];
				end else if (sum < OUT_SYMV) begin
					next_out = OUT_SYMV[OUT_W-1:0];
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			out_data <= '0;
			out_flag <= 1'b0;
		end else begin
			out_data <= next_out;
			out_flag <= next_flag;
		end
	end

	a_trunc_drop: assert property (@(posedge clock) disable iff (srst) // [RULE7]
		mode_q.rnd == RND_TRUNC && mode_q.sat == SAT_NONE
		|=> out_data == $past(low_kept))
		else $error("truncate result differs from kept bits");
	a_biased_up: assert property (@(posedge clock) disable iff (srst) // [RULE8]
		mode_q.rnd == RND_BIASED && mode_q.sat == SAT_NONE
		|=> out_data == OUT_W'($past(low_kept) + {{(OUT_W-1){1'b0}}, $past(half)}))
		else $error("biased rounding wrong");
	a_unbiased_even: assert property (@(posedge clock) disable iff (srst) // [RULE9]
		mode_q.rnd == RND_UNBIASED && mode_q.sat == SAT_NONE && half && !rest
		|=> out_data == OUT_W'($past(low_kept) + {{(OUT_W-1){1'b0}}, $past(lsb)}))
		else $error("exact half not rounded to even");
	a_sym_clip: assert property (@(posedge clock) disable iff (srst) // [RULE12]
		mode_q.sat == SAT_SYM |=> out_data != OUT_MINV[OUT_W-1:0])
		else $error("symmetric mode produced most negative code");
endmodule : scl_lane

/* core/scl_scaler.sv */
// streaming fixed-point scaler with register slave and interrupt
//
// What this block does
// [RULE1] slice wide input to configured output type
// [RULE2] zero shift keeps binary point aligned
// [RULE3] shift, then round, then saturate
// [RULE4] shift is constant or selected vector entry
// [RULE5] positive shift drops MSBs, adds gain
// [RULE6] negative shift sign-pads top, attenuates
// [RULE7] truncate drops low bits unchanged
// [RULE8] biased rounds up at half or more
// [RULE9] unbiased rounds above half, ties even
// [RULE10] multiplication factor adds no hardware
// [RULE11] vector lanes; valid and channel delayed matching
// [RULE12] saturation none, asymmetric or symmetric
// [RULE13] per-sample saturation flag output
// [RULE14] selector is zero-based vector index
// [RULE15] upstream marks real samples valid, tagged
// [RULE16] latency fixed across all settings
`timescale 1ns/1ps
module scl_scaler
	import scl_pkg::*;
#(
	// only changes how results are read; no logic depends on it
	parameter int MULT_FACTOR = 1 // [RULE10]
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	// sample stream in
	input wire logic [NLANE-1:0][IN_W-1:0] a_data,
	input wire scl_tag_t a_tag,
	input wire logic [SEL_W-1:0] a_shift,
	// sample stream out
	output logic [NLANE-1:0][OUT_W-1:0] q_data,
	output scl_tag_t q_tag,
	output logic [NLANE-1:0] q_exp,
	// interrupt
	output logic irq
);
	logic ack;
	logic rd_take;
	logic wr_take;
	logic [DATA_W-1:0] next_readdata;
	logic [CTRL_W-1:0] ctrl;
	logic signed [SH_W-1:0] shift_const;
	logic signed [SH_W-1:0] shift_vec [NSHIFT];
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_clear;
	logic [DATA_W-1:0] sat_count;
	logic [DATA_W-1:0] smp_count;
	scl_mode_t mode;
	logic signed [SH_W-1:0] sel_shift;
	scl_tag_t tag_d1;
	logic sat_any;

	// one wait cycle per access keeps read data registered
	assign waitrequest = (read | write) & ~ack;
	assign rd_take = read & ack;
	assign wr_take = write & ack;

	always_ff @(posedge clock) begin
		if (srst) begin
			ack <= 1'b0;
		end else begin
			ack <= (read | write) & ~ack;
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		next_readdata = '0;
		if (address == REG_CTRL) begin
			next_readdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
		end else if (address == REG_SHCONST) begin
			next_readdata = {{(DATA_W-SH_W){1'b0}}, shift_const};
		end else if (address == REG_IRQ_STAT) begin
			next_readdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
		end else if (address == REG_IRQ_EN) begin
			next_readdata = {{(DATA_W-IRQ_W){1'b0}}, irq_enable};
		end else if (address == REG_SAT_CNT) begin
			next_readdata = sat_count;
		end else if (address == REG_SMP_CNT) begin
			next_readdata = smp_count;
		end else begin
			for (int i = 0; i < NSHIFT; i++) begin
				if (address == ADDR_W'(REG_SHVEC + REG_STEP * i)) begin
					next_readdata = {{(DATA_W-SH_W){1'b0}}, shift_vec[i]};
				end
			end
		end
	end

	// latched while the master waits, so it stands at the taking edge
	always_ff @(posedge clock) begin
		if (srst) begin
			readdata <= '0;
		end else if (read && !ack) begin
			readdata <= next_readdata;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl <= CTRL_RST;
		end else if (wr_take && address == REG_CTRL) begin
			ctrl <= writedata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			shift_const <= SHIFT_RST;
		end else if (wr_take && address == REG_SHCONST) begin
			shift_const <= writedata[SH_W-1:0];
		end
	end

	// one write port per vector entry
	for (genvar g = 0; g < NSHIFT; g++) begin : g_shvec
		always_ff @(posedge clock) begin
			if (srst) begin
				shift_vec[g] <= SHIFT_RST;
			end else if (wr_take && address == ADDR_W'(REG_SHVEC + REG_STEP * g)) begin
				shift_vec[g] <= writedata[SH_W-1:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_enable <= IRQ_RST;
		end else if (wr_take && address == REG_IRQ_EN) begin
			irq_enable <= writedata[IRQ_W-1:0];
		end
	end

	// mode is sampled with the data in the lanes, so a change mid-stream
	// applies cleanly from one sample on
	assign mode.rnd = scl_round_t'(ctrl[CTRL_RND_LSB +: 2]);
	assign mode.sat = scl_sat_t'(ctrl[CTRL_SAT_LSB +: 2]);

	// selector indexes the vector from zero; upstream keeps it in range
	always_comb begin
		if (ctrl[CTRL_VEC_BIT]) begin
			sel_shift = shift_vec[a_shift]; // [RULE4] [RULE14]
		end else begin
			sel_shift = shift_const; // [RULE4]
		end
	end

	// every lane shares the shift and mode of the cycle [RULE11]
	for (genvar g = 0; g < NLANE; g++) begin : g_lane
		scl_lane u_lane (
			.clock(clock),
			.srst(srst),
			.in_data(a_data[g]),
			.in_shift(sel_shift),
			.in_mode(mode),
			.out_data(q_data[g]),
			.out_flag(q_exp[g]) // [RULE13]
		);
	end

	// tag follows the two lane stages whatever the settings [RULE11] [RULE16]
	always_ff @(posedge clock) begin
		if (srst) begin
			tag_d1 <= '0;
			q_tag <= '0;
		end else begin
			tag_d1 <= a_tag; // [RULE15]
			q_tag <= tag_d1;
		end
	end

	// flags only count when the sample is real
	assign sat_any = q_tag.v & (|q_exp);
	assign irq_event[IRQ_SAT] = sat_any;
	assign irq_event[IRQ_SMP] = q_tag.v;
	assign irq_clear = (wr_take && address == REG_IRQ_CLR) ?
		writedata[IRQ_W-1:0] : IRQ_RST;

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_status <= IRQ_RST;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_event; // [RULE13]
		end
	end

	assign irq = |(irq_status & irq_enable);

	// counters wrap; software reads differences
	always_ff @(posedge clock) begin
		if (srst) begin
			sat_count <= CNT_RST;
		end else if (sat_any) begin
			sat_count <= sat_count + DATA_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			smp_count <= CNT_RST;
		end else if (q_tag.v) begin
			smp_count <= smp_count + DATA_W'(1);
		end
	end

	sequence s_req_wait;
		(read || write) && waitrequest;
	endsequence

	sequence s_req_done;
		!waitrequest;
	endsequence

	a_bus_wait: assert property (@(posedge clock) disable iff (srst)
		s_req_wait |=> s_req_done)
		else $error("access not answered after one wait cycle");

	a_valid_delay: assert property (@(posedge clock) disable iff (srst) // [RULE11]
		a_tag.v |-> ##2 q_tag.v)
		else $error("valid not delayed by pipeline latency");

	a_invalid_delay: assert property (@(posedge clock) disable iff (srst) // [RULE16]
		!a_tag.v |-> ##2 !q_tag.v)
		else $error("spurious output valid");

	a_chan_delay: assert property (@(posedge clock) disable iff (srst) // [RULE11]
		a_tag.v |-> ##2 (q_tag.chan == $past(a_tag.chan, 2)))
		else $error("channel tag misaligned with data");

	a_sat_sticky: assert property (@(posedge clock) disable iff (srst) // [RULE13]
		sat_any |=> irq_status[IRQ_SAT] ##1 (irq_status[IRQ_SAT] || $past(irq_clear[IRQ_SAT])))
		else $error("saturation event lost");

	a_clear_bit: assert property (@(posedge clock) disable iff (srst)
		irq_clear[IRQ_SAT] && !sat_any |=> !irq_status[IRQ_SAT])
		else $error("status bit not cleared");
endmodule : scl_scaler

/* sim/scl_src.sv */
// upstream sample source feeding the scaler
`timescale 1ns/1ps
module scl_src
	import scl_pkg::*;
(
	// clock
	input wire logic clock,
	// stream to the scaler
	output logic [NLANE-1:0][IN_W-1:0] a_data,
	output scl_tag_t a_tag,
	output logic [SEL_W-1:0] a_shift
);
	initial begin
		a_data = '0;
		a_tag = '0;
		a_shift = '0;
	end
	// one real sample on the next edge, with a legal vector index
	task automatic put(input logic [NLANE-1:0][IN_W-1:0] d,
		input logic [CHAN_W-1:0] c, input logic [SEL_W-1:0] s);
		@(posedge clock);
		a_data <= d;
		a_tag <= '{v: 1'b1, chan: c};
		a_shift <= s;
	endtask : put
	// no sample: data flips so a stale word can never pass as fresh
	task automatic idle();
		@(posedge clock);
		a_tag.v <= 1'b0;
		a_data <= ~a_data;
		a_shift <= ~a_shift;
	endtask : idle
endmodule : scl_src

/* sim/testbench.sv */
// self-checking bench for the fixed-point scaler
`timescale 1ns/1ps
module testbench;
	import scl_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic [NLANE-1:0][IN_W-1:0] a_data;
	scl_tag_t a_tag;
	logic [SEL_W-1:0] a_shift;
	logic [NLANE-1:0][OUT_W-1:0] q_data;
	scl_tag_t q_tag;
	logic [NLANE-1:0] q_exp;
	logic irq;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	// shadow of the settings: ctrl and shc move by nba at the edge the write lands, shv after the read-back
	logic [4:0] ctrl = '0;
	int shc = 0;
	int shv [NSHIFT] = '{0, 0, 0, 0};
	logic [NLANE-1:0][16:0] ex [2];
	logic [8:0] et [2];
	bit ck [2] = '{0, 0};
	always #10 clock = ~clock;
	scl_src src_u (.clock(clock), .a_data(a_data), .a_tag(a_tag),
		.a_shift(a_shift));
	// the factor only relabels results, so expectations ignore it
	scl_scaler #(.MULT_FACTOR(4)) dut_u (.clock(clock), .srst(srst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .a_data(a_data), .a_tag(a_tag),
		.a_shift(a_shift), .q_data(q_data), .q_tag(q_tag),
		.q_exp(q_exp), .irq(irq));
	task automatic note(input bit bad, input logic [31:0] g,
		input logic [31:0] e);
		comparisons++;
		if (bad) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : note
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		note(g !== e, g, e);
	endtask : cmp_reg
	task automatic cmp_smp(input logic [16:0] g, input logic [16:0] e);
		note(g !== e, 32'(g), 32'(e));
	endtask : cmp_smp
	task automatic cmp_bit(input logic g, input logic e);
		note(g !== e, 32'(g), 32'(e));
	endtask : cmp_bit
	// expected {flag, word} of one lane under the current settings
	function automatic logic [16:0] ref_lane(logic [31:0] a, int s);
		longint n;
		longint k;
		longint lo;
		logic h;
		logic r;
		n = longint'($signed(a)) <<< (s + 8);
		k = n >>> 20;
		h = n[19];
		r = |n[18:0];
		if (ctrl[1:0] == 2'h1) k += longint'(h);
		if (ctrl[1:0] == 2'h2) k += longint'(h & (r | k[0]));
		lo = (ctrl[3:2] == 2'h2) ? -32767 : -32768;
		ref_lane[16] = (k > 32767) || (k < lo);
		if (ctrl[3:2] == 2'h1 || ctrl[3:2] == 2'h2) begin
			k = (k > 32767) ? 32767 : ((k < lo) ? lo : k);
		end
		ref_lane[15:0] = k[15:0];
	endfunction : ref_lane
	// every sample is judged two edges after it was taken
	always @(posedge clock) begin
		int s;
		if (ck[1]) begin
			cmp_smp({8'h00, q_tag}, {8'h00, et[1]});
			for (int i = 0; i < NLANE; i++)
				cmp_smp({q_exp[i], q_data[i]}, ex[1][i]);
		end
		s = ctrl[4] ? shv[a_shift] : shc;
		ex[1] = ex[0];
		for (int i = 0; i < NLANE; i++)
			ex[0][i] = ref_lane(a_data[i], s);
		et[1] = et[0];
		et[0] = a_tag;
		ck[1] = ck[0];
		ck[0] = !srst;
	end
	task automatic bus(input bit wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		do @(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		cmp_reg(q, e);
	endtask : rd
	task automatic set_ctrl(input logic [4:0] v);
		wr(REG_CTRL, 32'(v));
		ctrl <= v;
	endtask : set_ctrl
	task automatic drain();
		repeat (4) src_u.idle();
	endtask : drain
	task automatic t_regs();
		logic [ADDR_W-1:0] map [8] = '{REG_CTRL, REG_SHCONST, REG_SHVEC,
			REG_IRQ_STAT, REG_IRQ_EN, REG_SAT_CNT, REG_SMP_CNT, 6'h3C};
		foreach (map[i]) rd(map[i], 32'h0000_0000);
		wr(6'h3C, 32'hFFFF_FFFF);
		rd(6'h3C, 32'h0000_0000);
		wr(REG_CTRL, 32'hFFFF_FFFF);
		rd(REG_CTRL, 32'h0000_001F);
		set_ctrl(5'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_round();
		for (int m = 0; m < 3; m++) begin
			set_ctrl(5'(m));
			src_u.put({32'hFFFF_E800, 32'h0000_0C00, 32'h0000_0800,
				32'h0000_1800}, 8'(m), 2'h3);
			src_u.put({32'h7654_3210, 32'hFFFF_F7FF, 32'h8000_0FFF,
				32'h0000_07FF}, 8'h80, 2'h1);
			drain();
		end
		$display("t_round done");
	endtask : t_round
	task automatic t_sat();
		for (int m = 0; m < 3; m++) begin
			set_ctrl({1'b0, 2'(m), 2'h1});
			src_u.put({32'h07FF_F800, 32'hF800_0000, 32'h8000_0000,
				32'h7FFF_FFFF}, 8'h11, 2'h0);
			src_u.put({32'h07FF_F7FF, 32'hF800_0800, 32'h0000_0000,
				32'hFFFF_FFFF}, 8'h22, 2'h2);
			drain();
		end
		$display("t_sat done");
	endtask : t_sat
	task automatic t_shift();
		int v [NSHIFT] = '{0, 8, -8, -3};
		logic [NLANE-1:0][IN_W-1:0] d = {32'h0012_3456, 32'hFFED_CBA9,
			32'h0000_0101, 32'h0080_0000};
		for (int i = 0; i < NSHIFT; i++) begin
			wr(REG_SHVEC + 6'(4 * i), 32'(v[i] & 63));
			rd(REG_SHVEC + 6'(4 * i), 32'(v[i] & 63));
			shv[i] <= v[i];
		end
		set_ctrl(5'h16);
		for (int i = 0; i < 8; i++)
			src_u.put(d, 8'(i), 2'(i ^ (i >> 2) * 3));
		drain();
		set_ctrl(5'h06);
		wr(REG_SHCONST, 32'h0000_003D);
		shc <= -3;
		src_u.put(d, 8'h55, 2'h1);
		drain();
		$display("t_shift done");
	endtask : t_shift
	task automatic t_irq();
		logic [31:0] q;
		set_ctrl(5'h04);
		src_u.put({4{32'h0000_0100}}, 8'h01, 2'h0);
		drain();
		wr(REG_IRQ_CLR, 32'h0000_0003);
		wr(REG_IRQ_EN, 32'h0000_0002);
		rd(REG_IRQ_STAT, 32'h0000_0000);
		cmp_bit(irq, 1'b0);
		src_u.put({4{32'h0000_0100}}, 8'h02, 2'h0);
		drain();
		rd(REG_IRQ_STAT, 32'h0000_0002);
		cmp_bit(irq, 1'b1);
		wr(REG_IRQ_EN, 32'h0000_0001);
		rd(REG_IRQ_STAT, 32'h0000_0002);
		cmp_bit(irq, 1'b0);
		bus(1'b0, REG_SAT_CNT, 32'h0000_0000, q);
		src_u.put({4{32'h7FFF_FFFF}}, 8'h03, 2'h0);
		src_u.put({4{32'h0000_0100}}, 8'h04, 2'h0);
		drain();
		rd(REG_SAT_CNT, q + 32'h0000_0001);
		rd(REG_SMP_CNT, 32'h0000_0019);
		rd(REG_IRQ_STAT, 32'h0000_0003);
		cmp_bit(irq, 1'b1);
		wr(REG_IRQ_CLR, 32'h0000_0003);
		rd(REG_IRQ_STAT, 32'h0000_0000);
		cmp_bit(irq, 1'b0);
		$display("t_irq done");
	endtask : t_irq
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// a hang ends the run after far more cycles than the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		t_regs();
		t_round();
		t_sat();
		t_shift();
		t_irq();
		results();
	end
endmodule : testbench
